/* design/fpx_pkg.sv */
package fpx_pkg;

  // ----------------------------------------
  // register map (byte offsets)
  // ----------------------------------------
  localparam logic [11:0] FPX_STATUS_OFS = 12'h000;
  localparam logic [11:0] FPX_MASK_OFS = 12'h004;
  localparam logic [11:0] FPX_ENABLE_OFS = 12'h008;
  localparam logic [11:0] FPX_IRQ_STAT_OFS = 12'h00c;
  localparam logic [11:0] FPX_IRQ_MASK_OFS = 12'h010;
  localparam logic [11:0] FPX_LAST_OFS = 12'h014;

  // ----------------------------------------
  // flag bit positions
  // ----------------------------------------
  localparam int FPX_B_INV = 0;
  localparam int FPX_B_DEN = 1;
  localparam int FPX_B_ZDV = 2;
  localparam int FPX_B_OVF = 3;
  localparam int FPX_B_UNF = 4;
  localparam int FPX_B_PRC = 5;
  localparam int FPX_NFLAG = 6;

  localparam logic [5:0] FPX_MASK_RST = 6'h3f;
  localparam logic [5:0] FPX_FLAG_RST = 6'h00;
  localparam logic [1:0] FPX_IRQ_NONE = 2'h0;

  // ----------------------------------------
  // irq event bits
  // ----------------------------------------
  localparam int FPX_IB_DISP = 0;
  localparam int FPX_IB_FLAG = 1;

  // ----------------------------------------
  // last verdict word fields
  // ----------------------------------------
  localparam int FPX_LW_EV_LSB = 0;
  localparam int FPX_LW_DISP = 8;
  localparam int FPX_LW_FLAG_LSB = 9;

  // selected event causes
  typedef enum logic [3:0] {
    FPX_EV_NONE = 4'h0,
    FPX_EV_STK_UNF = 4'h1,
    FPX_EV_STK_OVF = 4'h2,
    FPX_EV_UNSUP = 4'h3,
    FPX_EV_SNAN = 4'h4,
    FPX_EV_INV_OTHER = 4'h5,
    FPX_EV_ZDIV = 4'h6,
    FPX_EV_DENORM = 4'h7,
    FPX_EV_OVF = 4'h8,
    FPX_EV_UNF = 4'h9,
    FPX_EV_PREC = 4'ha
  } fpx_event_t;

  // rounding modes
  typedef enum logic [1:0] {
    FPX_RND_NEAR = 2'h0,
    FPX_RND_DOWN = 2'h1,
    FPX_RND_UP = 2'h2,
    FPX_RND_ZERO = 2'h3
  } fpx_rnd_t;

  // overflow result selection
  typedef enum logic [1:0] {
    FPX_OVR_INF = 2'h0,
    FPX_OVR_MAXFIN = 2'h1,
    FPX_OVR_NONE = 2'h2
  } fpx_ovr_t;

  // raw conditions of one instruction from the datapath
  typedef struct packed {
    logic stack_unf;
    logic stack_ovf;
    logic unsup_fmt;
    logic snan;
    logic qnan;
    logic inv_other;
    logic zdiv;
    logic denorm;
    logic ovf;
    logic tiny;
    logic inexact;
    logic is_stack;
    logic is_ext;
    logic result_neg;
    fpx_rnd_t rnd;
  } fpx_cond_t;

  // per-instruction verdict
  typedef struct packed {
    fpx_event_t event_sel;
    logic dispatch;
    logic [5:0] flags;
    logic dest_write;
    logic biased_result;
    logic qnan_result;
    logic denorm_result;
    fpx_ovr_t ovf_result;
  } fpx_verdict_t;

endpackage

/* design/fpx_prioritizer.sv */
// Behaviour
// - rank: invalid, QNaN operand, other invalid/divide-by-zero, denormal, over/underflow, inexact
// - invalid sub-order: stack underflow, stack overflow, unsupported format, SNaN
// - other invalid causes and divide-by-zero share level three
// - coinciding masked conditions: only the highest one handled, QNaN returned when that one is invalid
// - QNaN operand pre-empts all lower conditions, no divide-by-zero raised
// - masked denormal lets execution continue to lower conditions
// - denormal or inexact handled alongside overflow or underflow
// - invalid, divide-by-zero, denormal judged from operands before arithmetic
// - overflow, underflow, precision judged only after true result exists
// - unmasked pre-operation event blocks any destination write
// - unmasked overflow/underflow: stack unit may write biased result, packed leaves destination
// - handler events go out on the common exception dispatch path
// - masked overflow sets flag, result by rounding mode and sign
// - masked underflow flags only tiny and inexact, still returns denormal
// - masked inexact alone sets precision flag, writes rounded result
`timescale 1ns/1ns
`default_nettype none
module fpx_prioritizer
  import fpx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pre_valid,
  input wire fpx_cond_t pre_cond,
  input wire logic post_valid,
  input wire logic post_tiny,
  input wire logic post_ovf,
  input wire logic post_inexact,
  output fpx_verdict_t verdict,
  output logic verdict_valid,
  output logic irq
);

  // ----------------------------------------
  // registers and bus decode
  // ----------------------------------------
  logic [5:0] flags_q;
  logic [5:0] mask_q;
  logic enable_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  fpx_verdict_t verdict_q;
  logic verdict_valid_q;
  fpx_cond_t held_q;
  logic held_busy_q;
  logic held_stop_q;
  fpx_verdict_t pre_v;
  fpx_verdict_t fin_v;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  fpx_verdict_t verdict_hold_q;
  logic done_pending_q;
  logic [31:0] last_word;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = (paddr == FPX_STATUS_OFS) || (paddr == FPX_MASK_OFS) ||
                   (paddr == FPX_ENABLE_OFS) || (paddr == FPX_IRQ_STAT_OFS) ||
                   (paddr == FPX_IRQ_MASK_OFS) || (paddr == FPX_LAST_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // last verdict word: event, dispatch, flags
  always_comb begin
    last_word = 32'h0000_0000;
    last_word[FPX_LW_EV_LSB +: $bits(fpx_event_t)] = verdict_q.event_sel;
    last_word[FPX_LW_DISP] = verdict_q.dispatch;
    last_word[FPX_LW_FLAG_LSB +: FPX_NFLAG] = verdict_q.flags;
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        FPX_STATUS_OFS: prdata = {26'h0, flags_q};
        FPX_MASK_OFS: prdata = {26'h0, mask_q};
        FPX_ENABLE_OFS: prdata = {31'h0, enable_q};
        FPX_IRQ_STAT_OFS: prdata = {30'h0, irq_stat_q};
        FPX_IRQ_MASK_OFS: prdata = {30'h0, irq_mask_q};
        FPX_LAST_OFS: prdata = last_word;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // pre-operation stage
  // ----------------------------------------
  always_comb begin
    pre_v = '0;
    pre_v.event_sel = FPX_EV_NONE;
    pre_v.ovf_result = FPX_OVR_NONE;
    pre_v.dest_write = 1'b1;
    // stack and format causes exist only on the stack unit
    if (pre_cond.is_stack && pre_cond.stack_unf) begin
      pre_v.flags[FPX_B_INV] = 1'b1;
      pre_v.event_sel = FPX_EV_STK_UNF;
    end else if (pre_cond.is_stack && pre_cond.stack_ovf) begin
      pre_v.flags[FPX_B_INV] = 1'b1;
      pre_v.event_sel = FPX_EV_STK_OVF;
    end else if (pre_cond.is_stack && pre_cond.is_ext && pre_cond.unsup_fmt) begin
      pre_v.flags[FPX_B_INV] = 1'b1;
      pre_v.event_sel = FPX_EV_UNSUP;
    end else if (pre_cond.snan) begin
      pre_v.flags[FPX_B_INV] = 1'b1;
      pre_v.event_sel = FPX_EV_SNAN;
    end else if (pre_cond.qnan) begin
      pre_v.qnan_result = 1'b1;
    end else if (pre_cond.inv_other) begin
      pre_v.flags[FPX_B_INV] = 1'b1;
      pre_v.event_sel = FPX_EV_INV_OTHER;
    end else if (pre_cond.zdiv) begin
      pre_v.flags[FPX_B_ZDV] = 1'b1;
      pre_v.event_sel = FPX_EV_ZDIV;
    end else if (pre_cond.denorm) begin
      pre_v.flags[FPX_B_DEN] = 1'b1;
      pre_v.event_sel = FPX_EV_DENORM;
    end
    if (pre_v.flags[FPX_B_INV] && mask_q[FPX_B_INV]) begin
      pre_v.qnan_result = 1'b1;
      pre_v.event_sel = FPX_EV_NONE;
    end else if (pre_v.flags[FPX_B_ZDV] && mask_q[FPX_B_ZDV]) begin
      pre_v.event_sel = FPX_EV_NONE;
    end else if (pre_v.flags[FPX_B_DEN] && mask_q[FPX_B_DEN]) begin
      pre_v.event_sel = FPX_EV_NONE;
    end
    if (pre_v.event_sel != FPX_EV_NONE) begin
      pre_v.dispatch = 1'b1;
      pre_v.dest_write = 1'b0;
    end
  end

  // continue to arithmetic only when no event stopped it
  logic pre_stop;
  assign pre_stop = pre_v.dispatch || pre_v.qnan_result ||
                    (pre_v.flags[FPX_B_INV] || pre_v.flags[FPX_B_ZDV]);

  // ----------------------------------------
  // post-operation stage
  // ----------------------------------------
  always_comb begin
    fin_v = verdict_hold_q;
    if (!held_stop_q) begin
      if (post_ovf) begin
        fin_v.flags[FPX_B_OVF] = 1'b1;
        if (mask_q[FPX_B_OVF]) begin
          case (held_q.rnd)
            FPX_RND_NEAR: fin_v.ovf_result = FPX_OVR_INF;
            FPX_RND_DOWN: fin_v.ovf_result = held_q.result_neg ? FPX_OVR_INF : FPX_OVR_MAXFIN;
            FPX_RND_UP: fin_v.ovf_result = held_q.result_neg ? FPX_OVR_MAXFIN : FPX_OVR_INF;
            default: fin_v.ovf_result = FPX_OVR_MAXFIN;
          endcase
        end else begin
          fin_v.event_sel = FPX_EV_OVF;
        end
      end else if (post_tiny) begin
        if (mask_q[FPX_B_UNF]) begin
          fin_v.flags[FPX_B_UNF] = post_inexact;
          fin_v.denorm_result = 1'b1;
        end else begin
          fin_v.flags[FPX_B_UNF] = 1'b1;
          fin_v.event_sel = FPX_EV_UNF;
        end
      end
      if (post_inexact) begin
        fin_v.flags[FPX_B_PRC] = 1'b1;
        if (!mask_q[FPX_B_PRC] && fin_v.event_sel == FPX_EV_NONE) begin
          fin_v.event_sel = FPX_EV_PREC;
        end
      end
      if (fin_v.event_sel == FPX_EV_OVF || fin_v.event_sel == FPX_EV_UNF) begin
        fin_v.dest_write = held_q.is_stack;
        fin_v.biased_result = held_q.is_stack;
        fin_v.denorm_result = 1'b0;
      end
      fin_v.dispatch = (fin_v.event_sel != FPX_EV_NONE);
    end
  end

  // ----------------------------------------
  // instruction hold between stages
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q <= '0;
      held_busy_q <= 1'b0;
      held_stop_q <= 1'b0;
      verdict_hold_q <= '0;
    end else if (pre_valid && enable_q) begin
      held_q <= pre_cond;
      held_busy_q <= !pre_stop;
      held_stop_q <= pre_stop;
      verdict_hold_q <= pre_v;
    end else if (post_valid) begin
      held_busy_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // completion and dispatch
  // ----------------------------------------
  logic done;
  assign done = held_busy_q ? post_valid : held_stop_q && !verdict_valid_q && done_pending_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_pending_q <= 1'b0;
    end else begin
      done_pending_q <= pre_valid && enable_q && pre_stop;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verdict_q <= '0;
      verdict_valid_q <= 1'b0;
    end else begin
      verdict_valid_q <= done;
      if (done) begin
        verdict_q <= fin_v;
      end
    end
  end

  assign verdict = verdict_q;
  assign verdict_valid = verdict_valid_q;

  // ----------------------------------------
  // control and sticky status
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= FPX_MASK_RST;
    end else if (wr_en && paddr == FPX_MASK_OFS) begin
      mask_q <= pwdata[FPX_NFLAG-1:0];
    end
  end

  // instructions are refused while this is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b1;
    end else if (wr_en && paddr == FPX_ENABLE_OFS) begin
      enable_q <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= FPX_IRQ_NONE;
    end else if (wr_en && paddr == FPX_IRQ_MASK_OFS) begin
      irq_mask_q <= pwdata[$bits(irq_mask_q)-1:0];
    end
  end

  logic [5:0] flag_clr;
  logic [1:0] irq_clr;
  logic [5:0] flag_set;
  logic [1:0] irq_set;
  assign flag_clr = (wr_en && paddr == FPX_STATUS_OFS) ? pwdata[FPX_NFLAG-1:0] : '0;
  assign irq_clr = (wr_en && paddr == FPX_IRQ_STAT_OFS) ? pwdata[$bits(irq_clr)-1:0] : '0;
  assign flag_set = verdict_valid_q ? verdict_q.flags : '0;
  always_comb begin
    irq_set = '0;
    irq_set[FPX_IB_DISP] = verdict_valid_q && verdict_q.dispatch;
    irq_set[FPX_IB_FLAG] = verdict_valid_q && (verdict_q.flags != '0);
  end

  // ----------------------------------------
  // sticky bits, one flop each
  // ----------------------------------------
  // a new set wins over a clear in the same cycle
  for (genvar gf = 0; gf < FPX_NFLAG; gf++) begin : g_flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flags_q[gf] <= FPX_FLAG_RST[gf];
      end else begin
        flags_q[gf] <= (flags_q[gf] && !flag_clr[gf]) || flag_set[gf];
      end
    end
  end

  for (genvar gs = 0; gs < $bits(irq_stat_q); gs++) begin : g_irq_stat
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_stat_q[gs] <= FPX_IRQ_NONE[gs];
      end else begin
        irq_stat_q[gs] <= (irq_stat_q[gs] && !irq_clr[gs]) || irq_set[gs];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

endmodule
`default_nettype wire

/* dv/fpx_prioritizer_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module fpx_prioritizer_monitor
  import fpx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pre_valid,
  input wire fpx_cond_t pre_cond,
  input wire logic post_valid,
  input wire fpx_verdict_t verdict,
  input wire logic verdict_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // completion sequences
  // ----------------------------------------
  sequence s_stop_done;
    ##2 verdict_valid;
  endsequence
  sequence s_post_done;
    ##1 verdict_valid ##1 !verdict_valid;
  endsequence
  a_apb_zero_wait: assert property (psel && penable |-> pready) else $error("pready low in access");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h014 |-> pslverr) else $error("no pslverr");
  a_pre_stop: assert property (pre_valid && (pre_cond.snan || pre_cond.qnan || pre_cond.zdiv) |-> s_stop_done)
    else $error("early stop late");
  a_post_done: assert property (post_valid |-> s_post_done) else $error("post verdict late");
  a_qnan_no_zdiv: assert property (pre_valid && pre_cond.qnan |-> ##2 !verdict.flags[FPX_B_ZDV])
    else $error("qnan raised zdiv");
  a_snan_wins: assert property (pre_valid && pre_cond.snan |-> ##2 verdict.flags[FPX_B_INV])
    else $error("snan lost");
  a_pre_blocks: assert property (verdict_valid && verdict.dispatch && verdict.event_sel <= FPX_EV_DENORM
    |-> !verdict.dest_write) else $error("write on pre event");
  a_dispatch_sel: assert property (verdict_valid && verdict.dispatch |-> verdict.event_sel != FPX_EV_NONE)
    else $error("dispatch without event");
  a_verdict_holds: assert property (!verdict_valid |-> $stable(verdict)) else $error("verdict moved");
  a_single_pulse: assert property (verdict_valid |=> !verdict_valid) else $error("double pulse");
endmodule
bind fpx_prioritizer fpx_prioritizer_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .pre_valid(pre_valid), .pre_cond(pre_cond),
  .post_valid(post_valid), .verdict(verdict), .verdict_valid(verdict_valid));
`default_nettype wire

/* dv/fpx_datapath_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fpx_datapath_model
  import fpx_pkg::*;
(
  input wire logic pclk,
  output logic pre_valid,
  output fpx_cond_t pre_cond,
  output logic post_valid,
  output logic [2:0] post_bits
);
  initial begin
    pre_valid = 1'b0;
    post_valid = 1'b0;
    pre_cond = '0;
    post_bits = 3'h0;
  end
  // released lines show the inverse, not the last value
  task automatic issue(input fpx_cond_t c, input logic go, input logic [2:0] tpo);
    @(posedge pclk);
    pre_valid <= 1'b1;
    pre_cond <= c;
    @(posedge pclk);
    pre_valid <= 1'b0;
    pre_cond <= ~c;
    if (go) begin
      @(posedge pclk);
      post_valid <= 1'b1;
      post_bits <= tpo;
      @(posedge pclk);
      post_valid <= 1'b0;
      post_bits <= ~tpo;
    end
  endtask
endmodule
`default_nettype wire

/* dv/fpx_prioritizer_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module fpx_prioritizer_bench;
  import fpx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pre_valid, post_valid, verdict_valid, irq, seen, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, t;
  logic [2:0] pb;
  fpx_cond_t pre_cond;
  fpx_verdict_t verdict, got;
  int n_fail, n_checks;
  fpx_prioritizer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pre_valid(pre_valid),
    .pre_cond(pre_cond), .post_valid(post_valid), .post_tiny(pb[2]), .post_ovf(pb[1]), .post_inexact(pb[0]),
    .verdict(verdict), .verdict_valid(verdict_valid), .irq(irq));
  fpx_datapath_model dp (.pclk(pclk), .pre_valid(pre_valid), .pre_cond(pre_cond), .post_valid(post_valid),
    .post_bits(pb));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) if (verdict_valid) begin
    got <= verdict;
    seen <= 1'b1;
  end
  function automatic fpx_cond_t mk(input logic [13:0] b, input logic [1:0] r);
    return fpx_cond_t'({b, r});
  endfunction
  function automatic logic [31:0] exp_flags(input logic den, input logic [2:0] p);
    return 32'({p[0], p[2] & p[0], p[1], 1'b0, den, 1'b0});
  endfunction
  function automatic logic [31:0] exp_ovr(input logic ovf, input logic neg, input logic [1:0] r);
    if (!ovf) return 32'(FPX_OVR_NONE);
    if (r == 2'h3 || (r == 2'h1 && !neg) || (r == 2'h2 && neg)) return 32'(FPX_OVR_MAXFIN);
    return 32'(FPX_OVR_INF);
  endfunction
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    n_checks++;
    if (a !== e) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input fpx_cond_t c, input logic go, input logic [2:0] tpo);
    int k;
    seen = 1'b0;
    dp.issue(c, go, tpo);
    for (k = 0; k < 10 && !seen; k++) @(posedge pclk);
    if (!seen) begin
      n_fail++;
      $display("mismatch t=%0t no verdict", $time);
    end
    @(posedge pclk);
  endtask
  task automatic test_done;
    $display("fails=%0d checks=%0d", n_fail, n_checks);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    $display("mismatch t=%0t watchdog expired", $time);
    test_done;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, seen} = '0;
    void'($urandom(32'h0e8856a1));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FPX_MASK_OFS, 32'h0);
    chk(rd, 32'(FPX_MASK_RST));
    apb(1'b0, 12'h0f0, 32'h0);
    chk({31'h0, err}, 32'h1);
    run(mk(14'h0480, 2'h0), 1'b0, 3'h0);
    chk(32'(got.flags), 32'h1);
    chk({31'h0, got.qnan_result}, 32'h1);
    run(mk(14'h0280, 2'h0), 1'b0, 3'h0);
    chk(32'(got.flags), 32'h0);
    chk({31'h0, got.qnan_result}, 32'h1);
    apb(1'b1, FPX_MASK_OFS, 32'h3e);
    apb(1'b1, FPX_IRQ_MASK_OFS, 32'h1);
    run(mk(14'h2404, 2'h0), 1'b0, 3'h0);
    chk(32'(got.event_sel), 32'(FPX_EV_STK_UNF));
    chk({30'h0, got.dispatch, got.dest_write}, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, FPX_IRQ_STAT_OFS, 32'h3);
    #1;
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, FPX_MASK_OFS, 32'h37);
    run(mk(14'h0004, 2'h0), 1'b1, 3'h2);
    chk(32'(got.event_sel), 32'(FPX_EV_OVF));
    chk({29'h0, got.dispatch, got.dest_write, got.biased_result}, 32'h7);
    run(mk(14'h0000, 2'h0), 1'b1, 3'h2);
    chk({29'h0, got.dispatch, got.dest_write, got.biased_result}, 32'h4);
    apb(1'b1, FPX_MASK_OFS, 32'h3b);
    run(mk(14'h00c0, 2'h0), 1'b0, 3'h0);
    chk(32'(got.event_sel), 32'(FPX_EV_ZDIV));
    chk(32'(got.flags), 32'h4);
    apb(1'b0, FPX_LAST_OFS, 32'h0);
    chk(rd, 32'h0000_0906);
    apb(1'b1, FPX_MASK_OFS, 32'h3f);
    repeat (30) begin
      t = $urandom;
      // a true result is never both huge and tiny
      t[3] = t[3] & ~t[2];
      run(mk({7'h0, t[0], 5'h0, t[4]}, t[6:5]), 1'b1, t[3:1]);
      chk(32'(got.flags), exp_flags(t[0], t[3:1]));
      chk(32'(got.ovf_result), exp_ovr(t[2], t[4], t[6:5]));
      chk({31'h0, got.dispatch}, 32'h0);
    end
    test_done;
  end
endmodule
`default_nettype wire
